// ### dfcs_ctrl.sv
// dual frequency calibration sequencer and loop-filter switch control
//
// Behaviour
// - dual_cal_mode at one: initialization calibrates both preset frequencies.
// - dual_cal_mode at zero: initialization calibrates only the selected frequency.
// - each calibrated frequency keeps its result in internal storage.
// - with calibration enabled, every frequency switch restarts calibration.
// - calibration seeds from the stored result and replaces it.
// - writing main_control_reg with vco_cal_enable and force_dual_init set calibrates both frequencies.
// - force_dual_init set recalibrates both on every toggle; host clears it.
// - a main_control_reg write with vco_cal_enable set calibrates; cleared bit recalibrates active only.
// - locked to the first frequency asserts loop_switch_a_ctrl.
// - on switching to the second, release switch a, assert switch b.
// - port power levels come from the active frequency set's fields.
// - each output buffer is open drain or push-pull per style bit.
// - with pin switching enabled, each pin toggle not on a main_control_reg write cycle alternates the active frequency.
// - freq_set_select defines the active frequency.
`include "dfcs_defines.svh"
module dfcs_ctrl
    import dfcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // main control register write
    input wire logic ctrl_wr,
    input dfcs_ctrl_t ctrl_wdata,
    // power per set, buffer style per port
    input dfcs_pwr_t pwr_set_a,
    input dfcs_pwr_t pwr_set_b,
    input wire logic tx_buffer_style,
    input wire logic rx_buffer_style,
    // pin from host
    input wire logic txrx_control_pin,
    // calibration engine interface
    input wire logic cal_step_valid,
    input wire logic cal_step_up,
    input wire logic cal_converged,
    output logic cal_busy,
    output dfcs_cal_t cal_code,
    output logic cal_idx,
    // status
    output logic active_freq,
    output logic cal_valid_a,
    output logic cal_valid_b,
    // pins and analog controls
    output logic loop_switch_a_ctrl,
    output logic loop_switch_b_ctrl,
    output dfcs_pwr_t port_power,
    output logic tx_open_drain,
    output logic rx_open_drain
);
    function automatic dfcs_cal_t cal_step(input dfcs_cal_t c, input logic up);
        dfcs_cal_t r;
        r = c;
        if (up && c != {`DFCS_CAL_W{1'b1}}) begin
            r = c + 8'h01;
        end else if (!up && c != '0) begin
            r = c - 8'h01;
        end
        return r;
    endfunction : cal_step

    logic pin_sync;
    logic pin_prev_r;
    logic pin_prev_nxt;
    dfcs_sync u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(txrx_control_pin),
        .pin_sync(pin_sync)
    );
    wire logic pin_toggle = pin_sync ^ pin_prev_r;

    dfcs_ctrl_t ctrl_r;
    dfcs_ctrl_t ctrl_nxt;
    dfcs_state_t st_r;
    dfcs_state_t st_nxt;
    logic act_r;
    logic act_nxt;
    logic both_r;
    logic both_nxt;
    logic widx_r;
    logic widx_nxt;
    dfcs_cal_t work_r;
    dfcs_cal_t work_nxt;
    logic [1:0] valid_r;
    logic [1:0] valid_nxt;
    logic sw_a_r;
    logic sw_a_nxt;
    logic sw_b_r;
    logic sw_b_nxt;
    dfcs_pwr_t pwr_r;
    dfcs_pwr_t pwr_nxt;
    logic txod_r;
    logic rxod_r;
    logic st_wr;
    dfcs_cal_t st_rd;
    logic busy_r;
    logic busy_nxt;
    logic cal_start;

    dfcs_cal_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(st_wr),
        .wr_idx(widx_r),
        .wr_data(work_r),
        .rd_idx(widx_nxt),
        .rd_data(st_rd)
    );

    always_comb begin
        ctrl_nxt = ctrl_r;
        st_nxt = st_r;
        act_nxt = act_r;
        both_nxt = both_r;
        widx_nxt = widx_r;
        work_nxt = work_r;
        valid_nxt = valid_r;
        sw_a_nxt = sw_a_r;
        sw_b_nxt = sw_b_r;
        st_wr = 1'b0;
        cal_start = 1'b0;
        pin_prev_nxt = pin_sync;
        if (ctrl_wr) begin
            ctrl_nxt = ctrl_wdata;
            act_nxt = ctrl_wdata.freq_set_select;
            // a write with vco_cal_enable set restarts calibration of the active set
            if (ctrl_wdata.vco_cal_enable) begin
                // both sets when forced or, at init, in dual mode
                both_nxt = ctrl_wdata.force_dual_init || ctrl_wdata.dual_cal_mode;
                // cleared force bit keeps the other set's data
                if (!ctrl_wdata.force_dual_init && valid_r[~ctrl_wdata.freq_set_select]) begin
                    both_nxt = 1'b0;
                end
                widx_nxt = ctrl_wdata.freq_set_select;
                st_nxt = DFCS_CAL_ACT;
                cal_start = 1'b1;
            end else begin
                // no calibration: a running one is dropped, switches follow the select
                st_nxt = DFCS_DONE;
            end
        // a pin edge that lands on a write cycle is lost
        end else if (ctrl_r.pin_freq_switch_enable && pin_toggle) begin
            act_nxt = ~act_r;
            if (ctrl_r.vco_cal_enable) begin
                both_nxt = ctrl_r.force_dual_init;
                widx_nxt = ~act_r;
                st_nxt = DFCS_CAL_ACT;
                cal_start = 1'b1;
            end else begin
                st_nxt = DFCS_DONE;
            end
        end else begin
            unique case (st_r)
                DFCS_IDLE: begin
                end
                DFCS_CAL_ACT, DFCS_CAL_OTH: begin
                    if (cal_step_valid) begin
                        work_nxt = cal_step(work_r, cal_step_up);
                    end
                    if (cal_converged) begin
                        st_wr = 1'b1;
                        valid_nxt[widx_r] = 1'b1;
                        if (st_r == DFCS_CAL_ACT && both_r) begin
                            widx_nxt = ~widx_r;
                            st_nxt = DFCS_CAL_OTH;
                            cal_start = 1'b1;
                        end else begin
                            st_nxt = DFCS_DONE;
                        end
                    end
                end
                DFCS_DONE: begin
                    st_nxt = DFCS_IDLE;
                end
                default: begin
                    st_nxt = DFCS_IDLE;
                end
            endcase
        end
        // each new calibration seeds from the stored result, a restart mid-run too
        if (cal_start) begin
            work_nxt = st_rd;
        end
        // busy is registered so the output comes straight from a flop
        busy_nxt = (st_nxt == DFCS_CAL_ACT) || (st_nxt == DFCS_CAL_OTH);
        // loop switches move only once the active set has settled
        if (st_r == DFCS_DONE) begin
            sw_a_nxt = ~act_r;
            sw_b_nxt = act_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            st_r <= DFCS_IDLE;
            busy_r <= 1'b0;
            act_r <= 1'b0;
            both_r <= 1'b0;
            widx_r <= 1'b0;
            work_r <= `DFCS_CAL_RST;
            valid_r <= 2'h0;
            sw_a_r <= 1'b0;
            sw_b_r <= 1'b0;
            pin_prev_r <= 1'b0;
            pwr_r <= '0;
            txod_r <= 1'b0;
            rxod_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            st_r <= st_nxt;
            busy_r <= busy_nxt;
            act_r <= act_nxt;
            both_r <= both_nxt;
            widx_r <= widx_nxt;
            work_r <= work_nxt;
            valid_r <= valid_nxt;
            sw_a_r <= sw_a_nxt;
            sw_b_r <= sw_b_nxt;
            pin_prev_r <= pin_prev_nxt;
            pwr_r <= pwr_nxt;
            txod_r <= tx_buffer_style;
            rxod_r <= rx_buffer_style;
        end
    end

    always_comb begin
        pwr_nxt = act_r ? pwr_set_b : pwr_set_a;
    end

    assign cal_busy = busy_r;
    assign cal_code = work_r;
    assign cal_idx = widx_r;
    assign active_freq = act_r;
    assign cal_valid_a = valid_r[0];
    assign cal_valid_b = valid_r[1];
    assign loop_switch_a_ctrl = sw_a_r;
    assign loop_switch_b_ctrl = sw_b_r;
    assign port_power = pwr_r;
    assign tx_open_drain = txod_r;
    assign rx_open_drain = rxod_r;

    sw_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cal_busy |=> $stable(loop_switch_a_ctrl) && $stable(loop_switch_b_ctrl))
        else $error("loop switches moved during calibration");
    sw_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(st_r) == DFCS_DONE |-> loop_switch_b_ctrl == $past(act_r)
            && loop_switch_a_ctrl == !loop_switch_b_ctrl)
        else $error("loop switch does not follow active frequency");
    store_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cal_busy |=> $stable(valid_r))
        else $error("store changed without calibration");
    pin_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_wr && ctrl_r.pin_freq_switch_enable && pin_toggle |=> active_freq != $past(active_freq))
        else $error("pin toggle did not switch frequency");
    switch_cal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_wr && ctrl_r.pin_freq_switch_enable && pin_toggle && ctrl_r.vco_cal_enable
        |=> st_r == DFCS_CAL_ACT && cal_code == $past(st_rd))
        else $error("switch did not restart seeded calibration");
    write_cal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && ctrl_wdata.vco_cal_enable |=> st_r == DFCS_CAL_ACT
            && cal_idx == $past(ctrl_wdata.freq_set_select))
        else $error("control write did not start calibration");
    force_both_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && ctrl_wdata.vco_cal_enable && ctrl_wdata.force_dual_init |=> both_r)
        else $error("forced init not calibrating both");
    select_act_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr |=> active_freq == $past(ctrl_wdata.freq_set_select))
        else $error("select bit not applied");
    // guarded by the previous reset level, so the first edge after release is not judged
    power_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> port_power == ($past(act_r) ? $past(pwr_set_b) : $past(pwr_set_a)))
        else $error("port power not from active set");

    // sequencing checks
    dual_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && ctrl_wdata.vco_cal_enable && ctrl_wdata.dual_cal_mode
            && !valid_r[~ctrl_wdata.freq_set_select] |=> both_r)
        else $error("dual mode init not calibrating both");
    single_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && ctrl_wdata.vco_cal_enable && !ctrl_wdata.force_dual_init
            && (!ctrl_wdata.dual_cal_mode || valid_r[~ctrl_wdata.freq_set_select]) |=> !both_r)
        else $error("single calibration also scheduled the other set");
    no_cal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && !ctrl_wdata.vco_cal_enable |=> !cal_busy)
        else $error("calibration ran while disabled");
    both_cal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r == DFCS_CAL_ACT && both_r && cal_converged && !ctrl_wr
            && !(ctrl_r.pin_freq_switch_enable && pin_toggle)
        |=> st_r == DFCS_CAL_OTH && cal_idx != $past(cal_idx))
        else $error("second set not calibrated after the first");
    store_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cal_busy && cal_converged && !ctrl_wr
            && !(ctrl_r.pin_freq_switch_enable && pin_toggle)
        |=> valid_r[$past(widx_r)])
        else $error("converged result not kept");
    reg_switch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && !ctrl_wdata.vco_cal_enable |=> ##1 loop_switch_b_ctrl == $past(ctrl_wdata.freq_set_select, 2)
            && loop_switch_a_ctrl != loop_switch_b_ctrl)
        else $error("register select did not move the loop switches");
endmodule : dfcs_ctrl

// ### dfcs_defines.svh
// constants of the dual frequency calibration and switch controller
`ifndef DFCS_DEFINES_SVH
`define DFCS_DEFINES_SVH
`define DFCS_CAL_W 8
`define DFCS_PWR_W 6
`define DFCS_CAL_RST 8'h80
`define DFCS_CAL_STEP_MAX 8'h10
`endif

// ### dfcs_pkg.sv
// types of the dual frequency calibration and switch controller
`include "dfcs_defines.svh"
package dfcs_pkg;
    typedef logic [`DFCS_CAL_W-1:0] dfcs_cal_t;
    typedef struct packed {
        logic dual_cal_mode;
        logic vco_cal_enable;
        logic force_dual_init;
        logic freq_set_select;
        logic pin_freq_switch_enable;
    } dfcs_ctrl_t;
    typedef struct packed {
        logic [`DFCS_PWR_W-1:0] tx_port_power_level;
        logic [`DFCS_PWR_W-1:0] rx_port_power_level;
    } dfcs_pwr_t;
    typedef enum logic [3:0] {
        DFCS_IDLE = 4'h1,
        DFCS_CAL_ACT = 4'h2,
        DFCS_CAL_OTH = 4'h4,
        DFCS_DONE = 4'h8
    } dfcs_state_t;
endpackage : dfcs_pkg

// ### dfcs_sync.sv
// two-flop synchroniser for a pin input
module dfcs_sync
    import dfcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pin in, synchronised out
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end
    assign pin_sync = sync_r;
endmodule : dfcs_sync

// ### dfcs_cal_store.sv
// two-entry store of calibration results, one per preset frequency
`include "dfcs_defines.svh"
module dfcs_cal_store
    import dfcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic wr_idx,
    input dfcs_cal_t wr_data,
    // read port
    input wire logic rd_idx,
    output dfcs_cal_t rd_data
);
    dfcs_cal_t mem_r [2];
    dfcs_cal_t mem_nxt [2];
    always_comb begin
        mem_nxt = mem_r;
        if (wr_en) begin
            mem_nxt[wr_idx] = wr_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_r[0] <= `DFCS_CAL_RST;
            mem_r[1] <= `DFCS_CAL_RST;
        end else begin
            mem_r <= mem_nxt;
        end
    end
    assign rd_data = mem_r[rd_idx];
endmodule : dfcs_cal_store

// ### dfcs_cal_eng.sv
// calibration engine model: pauses, steps a few times, then converges
module dfcs_cal_eng
    import dfcs_pkg::*;
#(
    parameter int STEPS = 3
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // from the controller
    input wire logic cal_busy,
    input wire logic cal_idx,
    // to the controller
    output logic cal_step_valid,
    output logic cal_step_up,
    output logic cal_converged
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    // quiet cycles after each end, so no step can land on the set just finished
    always_comb begin
        cnt_nxt = (cal_busy && !cal_converged) ? cnt_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign cal_step_valid = cal_busy && cnt_r >= 8'h03 && cnt_r < 8'(STEPS + 3);
    // first set moves up, second down, so the two stored results differ
    assign cal_step_up = !cal_idx;
    assign cal_converged = cal_busy && cnt_r == 8'(STEPS + 4);
endmodule : dfcs_cal_eng

// ### dfcs_ctrl_tb.sv
// self-checking bench of the dual frequency calibration and switch controller
module dfcs_ctrl_tb
    import dfcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEPS = 3;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_wr = 1'b0;
    dfcs_ctrl_t ctrl_wdata = '0;
    dfcs_pwr_t pwr_set_a = 12'h54a;
    dfcs_pwr_t pwr_set_b = 12'h2b3;
    logic tx_buffer_style = 1'b0;
    logic rx_buffer_style = 1'b1;
    logic txrx_control_pin = 1'b0;
    logic cal_step_valid, cal_step_up, cal_converged, cal_busy, cal_idx, active_freq;
    logic cal_valid_a, cal_valid_b, loop_switch_a_ctrl, loop_switch_b_ctrl, tx_open_drain, rx_open_drain;
    dfcs_cal_t cal_code;
    dfcs_pwr_t port_power;
    int bad_count = 0;
    int checks_done = 0;
    dfcs_cal_t st [2];
    logic act;
    always #4 core_clk = ~core_clk;
    dfcs_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .pwr_set_a(pwr_set_a), .pwr_set_b(pwr_set_b), .tx_buffer_style(tx_buffer_style),
        .rx_buffer_style(rx_buffer_style), .txrx_control_pin(txrx_control_pin),
        .cal_step_valid(cal_step_valid), .cal_step_up(cal_step_up), .cal_converged(cal_converged),
        .cal_busy(cal_busy), .cal_code(cal_code), .cal_idx(cal_idx), .active_freq(active_freq),
        .cal_valid_a(cal_valid_a), .cal_valid_b(cal_valid_b), .loop_switch_a_ctrl(loop_switch_a_ctrl),
        .loop_switch_b_ctrl(loop_switch_b_ctrl), .port_power(port_power),
        .tx_open_drain(tx_open_drain), .rx_open_drain(rx_open_drain));
    dfcs_cal_eng #(.STEPS(STEPS)) eng_u (.core_clk(core_clk), .rst_n(rst_n), .cal_busy(cal_busy),
        .cal_idx(cal_idx), .cal_step_valid(cal_step_valid), .cal_step_up(cal_step_up),
        .cal_converged(cal_converged));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check("rst_code", cal_code, 12'h080);
        check("rst_out", {cal_busy, active_freq, loop_switch_a_ctrl, loop_switch_b_ctrl}, 12'h000);
        st = '{8'h80, 8'h80};
        act = 1'b0;
    endtask : do_reset
    // bits: dual mode, cal enable, force dual, select, pin switching
    task automatic wr(input logic [4:0] d);
        @(posedge core_clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= d;
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic toggle();
        act = !act;
        @(posedge core_clk);
        txrx_control_pin <= ~txrx_control_pin;
        #1;
    endtask : toggle
    // one calibration run: seeds, number of sets, switch a held, final switch state
    task automatic cal_check(input logic idx0, input int phases);
        int n;
        int ph;
        logic swa;
        n = 20;
        while (cal_busy !== 1'b1 && n > 0) begin
            tick(1);
            n--;
        end
        if (n == 0) begin
            bad_count++;
            final_report();
        end
        check("active", active_freq, act);
        check("idx", cal_idx, idx0);
        check("seed", cal_code, st[idx0]);
        swa = loop_switch_a_ctrl;
        ph = 1;
        n = 400;
        while (cal_busy === 1'b1 && n > 0) begin
            if (cal_idx !== idx0 && ph == 1) begin
                ph = 2;
                check("seed2", cal_code, st[!idx0]);
            end
            check("hold", loop_switch_a_ctrl, swa);
            tick(1);
            n--;
        end
        if (n == 0) begin
            bad_count++;
            final_report();
        end
        check("phases", 12'(ph), 12'(phases));
        for (int i = 0; i < ph; i++) begin
            st[idx0 ^ i[0]] = (idx0 ^ i[0]) ? st[1] - 8'(STEPS) : st[0] + 8'(STEPS);
        end
        tick(2);
        check("sw_a", loop_switch_a_ctrl, !act);
        check("sw_b", loop_switch_b_ctrl, act);
        check("power", port_power, act ? pwr_set_b : pwr_set_a);
    endtask : cal_check
    initial begin
        do_reset();
        wr(5'h08);
        cal_check(1'b0, 1);
        check("valid", {cal_valid_a, cal_valid_b}, 12'h002);
        $display("test single init done");
        do_reset();
        wr(5'h19);
        cal_check(1'b0, 2);
        check("valid", {cal_valid_a, cal_valid_b}, 12'h003);
        for (int i = 0; i < 3; i++) begin
            toggle();
            cal_check(act, 1);
        end
        $display("test pin switching done");
        wr({3'b111, act, 1'b1});
        cal_check(act, 2);
        toggle();
        cal_check(act, 2);
        wr({3'b110, act, 1'b1});
        cal_check(act, 1);
        toggle();
        cal_check(act, 1);
        $display("test forced dual done");
        act = !act;
        wr({3'b110, act, 1'b0});
        cal_check(act, 1);
        check("style0", {tx_open_drain, rx_open_drain}, 12'h001);
        act = !act;
        wr({3'b100, act, 1'b0});
        tick(10);
        check("no_cal", cal_busy, 1'b0);
        check("reg_sel", {active_freq, loop_switch_a_ctrl, loop_switch_b_ctrl}, {9'h000, act, !act, act});
        check("power_b", port_power, pwr_set_b);
        @(posedge core_clk);
        tx_buffer_style <= 1'b1;
        rx_buffer_style <= 1'b0;
        tick(3);
        check("style", {tx_open_drain, rx_open_drain}, 12'h002);
        $display("test register select and style done");
        final_report();
    end
endmodule : dfcs_ctrl_tb
